/* File: shared/sdram_ctrl_pkg.sv */
// Shared constants, timing counts and encodings for the SDRAM controller
package sdram_ctrl_pkg;
    localparam int CLK_NS = 10;
    localparam int MEM_DIV = 2;
    localparam int TICK_NS = CLK_NS * MEM_DIV;

    function automatic int ns_to_ticks(input int ns);
        return (ns + TICK_NS - 1) / TICK_NS;
    endfunction

    localparam int TRP_NS = 20;
    localparam int TRCD_NS = 20;
    localparam int TRFC_NS = 70;
    localparam int TMRD_NS = 20;
    localparam int TXSR_NS = 80;
    localparam logic [3:0] TRP_TK = 4'(ns_to_ticks(TRP_NS));
    localparam logic [3:0] TRCD_TK = 4'(ns_to_ticks(TRCD_NS));
    localparam logic [3:0] TRFC_TK = 4'(ns_to_ticks(TRFC_NS));
    localparam logic [3:0] TMRD_TK = 4'(ns_to_ticks(TMRD_NS));
    localparam logic [3:0] TXSR_TK = 4'(ns_to_ticks(TXSR_NS));
    localparam int REF_NS = 7800;
    localparam logic [9:0] REF_CYC = 10'(REF_NS / CLK_NS);
    localparam logic [4:0] RD_EXTRA = 5'h03;

    localparam int ADDR_W = 28;
    localparam int COL_MIN_W = 8;
    localparam int ROW_MIN_W = 11;
    localparam logic [1:0] ROW_SEL_MAX = 2'h2;
    localparam int AP_BIT = 10;
    localparam logic [3:0] MASK_NONE = 4'hf;

    typedef enum logic [3:0] {
        CMD_LMR = 4'b0000,
        CMD_REF = 4'b0001,
        CMD_PRE = 4'b0010,
        CMD_ACT = 4'b0011,
        CMD_WR  = 4'b0100,
        CMD_RD  = 4'b0101,
        CMD_DPD = 4'b0110,
        CMD_NOP = 4'b0111
    } cmd_t;

    typedef enum logic [1:0] {
        MODE_RUN      = 2'b00,
        MODE_SELF_REF = 2'b01,
        MODE_PWR_DOWN = 2'b10,
        MODE_DEEP_PD  = 2'b11
    } mode_t;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_ACT    = 4'h1,
        ST_RW     = 4'h2,
        ST_RDWAIT = 4'h3,
        ST_REF    = 4'h4,
        ST_LMR    = 4'h5,
        ST_LOWP   = 4'h6,
        ST_SLEEP  = 4'h7
    } state_t;

    function automatic logic [1:0] eff_cas(input logic [1:0] c);
        return (c == 2'h0) ? 2'h1 : c;
    endfunction

    function automatic logic [12:0] low_mask(input logic [3:0] w);
        return 13'((14'h0001 << w) - 14'h0001);
    endfunction
endpackage

/* File: hdl/sdram_addr_split.sv */
// Splits a system address into column, row and bank fields
`timescale 1ns/1ns
module sdram_addr_split
    import sdram_ctrl_pkg::*;
(
    // Address and geometry
    input wire logic [27:0] i_addr,
    input wire logic i_bus16,
    input wire logic [1:0] i_col_sel,
    input wire logic [1:0] i_row_sel,
    // Fields
    output logic [10:0] o_col,
    output logic [12:0] o_row,
    output logic [1:0] o_bank_field
);
    logic [1:0] lane_w;
    logic [3:0] col_w;
    logic [3:0] row_w;
    logic [27:0] after_col;
    logic [27:0] after_row;
    logic [27:0] bank_src;

    always_comb begin
        lane_w = i_bus16 ? 2'h1 : 2'h2;
        col_w = 4'(COL_MIN_W) + {2'h0, i_col_sel}; // RULE3
        // Undefined row code falls back to the widest row field
        row_w = 4'(ROW_MIN_W) + ((i_row_sel > ROW_SEL_MAX) ? {2'h0, ROW_SEL_MAX} : {2'h0, i_row_sel}); // RULE2
        after_col = i_addr >> lane_w; // RULE12
        o_col = 11'(after_col[12:0] & low_mask(col_w));
        after_row = after_col >> col_w; // RULE13
        o_row = after_row[12:0] & low_mask(row_w); // RULE14
        bank_src = after_row >> row_w;
        o_bank_field = bank_src[1:0];
    end
endmodule

/* File: hdl/sdram_ctrl.sv */
// SDRAM controller front end: request port, row tracking, command sequencing
// Functional notes
// RULE1: Memory data path is 16 or 32 bits, chosen by configuration input.
// RULE2: Row counts of 2048, 4096 or 8192 are supported.
// RULE3: Column counts 256 to 2048 widen the column field accordingly.
// RULE4: Byte, half-word and word system transfers, lanes picked by byte masks.
// RULE5: Every read or write uses burst length one.
// RULE6: Open row per bank is remembered and reused without reactivation.
// RULE7: CAS latency 1, 2 or 3; read data captured after that latency.
// RULE8: Self-refresh, power-down and deep power-down modes are offered.
// RULE9: Chip select and strobes active low, clock enable active high.
// RULE10: Four active-low lane masks, low only on lanes the transfer uses.
// RULE11: Address split follows configured memory geometry.
// RULE12: 32-bit, 2K rows: byte bits, 8-11 bit column, 11-bit row, bank.
// RULE13: 32-bit, 4K rows: 12-bit row between column and 2-bit bank.
// RULE14: 32-bit, 8K rows: 13-bit row above column, then 2-bit bank.
// RULE15: Periodic refresh outside self-refresh, arbitrated with accesses.
// RULE16: Software should keep unrelated data in different banks.
`timescale 1ns/1ns
module sdram_ctrl
    import sdram_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // System request
    input wire logic I_REQ,
    input wire logic I_WRITE,
    input wire logic [27:0] I_ADDR,
    input wire logic [1:0] I_SIZE,
    input wire logic [31:0] I_WDATA,
    output logic O_BUSY,
    output logic O_ACK,
    output logic [31:0] O_RDATA,
    // Configuration and status
    input wire logic I_BUS16,
    input wire logic [1:0] I_COL_SEL,
    input wire logic [1:0] I_ROW_SEL,
    input wire logic [1:0] I_CAS_LAT,
    input wire logic [1:0] I_MODE,
    output logic O_ASLEEP,
    // Memory pins
    output logic O_MEM_CLK_OUT,
    output logic O_MEM_CLK_EN,
    output logic O_MEM_CHIP_SEL_N,
    output logic O_ROW_STROBE_N,
    output logic O_COL_STROBE_N,
    output logic O_MEM_WRITE_STROBE_N,
    output logic [1:0] O_BANK_FIELD,
    output logic [12:0] O_MEM_ADDR_OUT,
    output logic [3:0] O_BYTE_LANE_MASK_N,
    output logic [31:0] O_DQ_OUT,
    output logic O_DQ_OE,
    input wire logic [31:0] I_DQ_IN
);
    logic mem_clk_r;
    logic tick;
    logic [31:0] dq_s1_r;
    logic [31:0] dq_s2_r;
    logic busy_r;
    logic write_r;
    logic [27:0] addr_r;
    logic [1:0] size_r;
    logic [31:0] wdata_r;
    logic [9:0] ref_cnt_r;
    logic ref_pend_r;
    logic ref_done;
    state_t state_r;
    cmd_t cmd_r;
    logic [3:0] wait_r;
    logic cke_r;
    logic [12:0] addr_o_r;
    logic [1:0] bank_o_r;
    logic [3:0] mask_r;
    logic [31:0] dq_out_r;
    logic dq_oe_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic part_r;
    logic [4:0] rd_cnt_r;
    logic [3:0] open_v_r;
    logic [12:0] open_row_r [4];
    logic lmr_need_r;
    logic [1:0] cas_prog_r;
    mode_t sleep_mode_r;
    logic asleep_r;
    logic [27:0] acc_addr;
    logic [10:0] sp_col;
    logic [12:0] sp_row;
    logic [1:0] sp_bank;
    logic hsel;
    logic need_second;
    logic [1:0] cas_eff;
    logic [3:0] lane_n;
    logic [31:0] wr_word;

    // Memory clock is the system clock halved; commands change on its falling edge
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            mem_clk_r <= 1'b0;
        end else begin
            mem_clk_r <= ~mem_clk_r;
        end
    end
    assign tick = mem_clk_r;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            dq_s1_r <= 32'h0;
            dq_s2_r <= 32'h0;
        end else begin
            dq_s1_r <= I_DQ_IN;
            dq_s2_r <= dq_s1_r;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            busy_r <= 1'b0;
            write_r <= 1'b0;
            addr_r <= 28'h0;
            size_r <= SZ_BYTE;
            wdata_r <= 32'h0;
        end else if (I_REQ && !busy_r) begin
            busy_r <= 1'b1;
            write_r <= I_WRITE;
            addr_r <= I_ADDR;
            size_r <= I_SIZE; // RULE4
            wdata_r <= I_WDATA;
        end else if (ack_r) begin
            busy_r <= 1'b0;
        end
    end

    // Expiry wins over the clear so a refresh due in the same cycle is kept
    assign ref_done = tick && (wait_r == 4'h0) && (state_r == ST_REF);
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ref_cnt_r <= REF_CYC - 10'h001;
            ref_pend_r <= 1'b0;
        end else begin
            ref_cnt_r <= (ref_cnt_r == 10'h000) ? REF_CYC - 10'h001 : ref_cnt_r - 10'h001;
            if (ref_cnt_r == 10'h000) begin
                ref_pend_r <= 1'b1; // RULE15
            end else if (ref_done) begin
                ref_pend_r <= 1'b0;
            end
        end
    end

    // Second half of a word on the narrow bus lands on the next column
    assign acc_addr = {addr_r[27:2], addr_r[1] | part_r, addr_r[0]};
    sdram_addr_split u_split (
        .i_addr(acc_addr),
        .i_bus16(I_BUS16),
        .i_col_sel(I_COL_SEL),
        .i_row_sel(I_ROW_SEL),
        .o_col(sp_col),
        .o_row(sp_row),
        .o_bank_field(sp_bank)
    ); // RULE11

    assign hsel = (size_r == SZ_WORD) ? part_r : addr_r[1];
    assign need_second = I_BUS16 && (size_r == SZ_WORD) && !part_r; // RULE1
    assign cas_eff = eff_cas(I_CAS_LAT);
    assign wr_word = I_BUS16 ? {16'h0, hsel ? wdata_r[31:16] : wdata_r[15:0]} : wdata_r;

    always_comb begin
        lane_n = MASK_NONE;
        if (I_BUS16) begin
            lane_n[1:0] = (size_r == SZ_BYTE) ? ~(2'h1 << addr_r[0]) : 2'h0; // RULE10
        end else if (size_r == SZ_WORD) begin
            lane_n = 4'h0;
        end else if (size_r == SZ_HALF) begin
            lane_n = addr_r[1] ? 4'h3 : 4'hc;
        end else begin
            lane_n = ~(4'h1 << addr_r[1:0]); // RULE4
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= ST_IDLE;
            wait_r <= 4'h0;
            cmd_r <= CMD_NOP;
            cke_r <= 1'b1;
            addr_o_r <= 13'h0;
            bank_o_r <= 2'h0;
            mask_r <= MASK_NONE;
            dq_out_r <= 32'h0;
            dq_oe_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            part_r <= 1'b0;
            rd_cnt_r <= 5'h0;
            open_v_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                open_row_r[i] <= 13'h0;
            end
            lmr_need_r <= 1'b1;
            cas_prog_r <= 2'h1;
            sleep_mode_r <= MODE_RUN;
            asleep_r <= 1'b0;
        end else begin
            ack_r <= 1'b0;
            if (tick) begin
                cmd_r <= CMD_NOP;
                dq_oe_r <= 1'b0;
                mask_r <= MASK_NONE;
            end
            if (state_r == ST_RDWAIT) begin
                rd_cnt_r <= rd_cnt_r - 5'h01;
                if (rd_cnt_r == 5'h01) begin
                    if (!I_BUS16) begin
                        rdata_r <= dq_s2_r; // RULE7
                    end else if (hsel) begin
                        rdata_r[31:16] <= dq_s2_r[15:0];
                    end else begin
                        rdata_r[15:0] <= dq_s2_r[15:0];
                    end
                    if (need_second) begin
                        part_r <= 1'b1;
                        state_r <= ST_RW;
                    end else begin
                        part_r <= 1'b0;
                        ack_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
            end else if (tick) begin
                if (wait_r != 4'h0) begin
                    wait_r <= wait_r - 4'h1;
                end else begin
                    case (state_r)
                        ST_IDLE: begin
                            // Housekeeping first, then the pending access
                            if (lmr_need_r || cas_prog_r != cas_eff ||
                                ref_pend_r || I_MODE != MODE_RUN) begin
                                cmd_r <= CMD_PRE;
                                addr_o_r <= 13'h1 << AP_BIT;
                                open_v_r <= 4'h0;
                                wait_r <= TRP_TK;
                                if (lmr_need_r || cas_prog_r != cas_eff) begin
                                    state_r <= ST_LMR;
                                end else if (ref_pend_r) begin
                                    state_r <= ST_REF; // RULE15
                                end else begin
                                    sleep_mode_r <= mode_t'(I_MODE);
                                    state_r <= ST_LOWP; // RULE8
                                end
                            end else if (busy_r && !ack_r) begin
                                if (open_v_r[sp_bank] && open_row_r[sp_bank] == sp_row) begin
                                    state_r <= ST_RW; // RULE6
                                end else if (open_v_r[sp_bank]) begin
                                    cmd_r <= CMD_PRE;
                                    addr_o_r <= 13'h0;
                                    bank_o_r <= sp_bank;
                                    open_v_r[sp_bank] <= 1'b0;
                                    wait_r <= TRP_TK;
                                    state_r <= ST_ACT;
                                end else begin
                                    state_r <= ST_ACT;
                                end
                            end
                        end
                        ST_ACT: begin
                            cmd_r <= CMD_ACT;
                            addr_o_r <= sp_row;
                            bank_o_r <= sp_bank;
                            open_v_r[sp_bank] <= 1'b1; // RULE6
                            open_row_r[sp_bank] <= sp_row;
                            wait_r <= TRCD_TK;
                            state_r <= ST_RW;
                        end
                        ST_RW: begin
                            // Column bit 10 moves to A11 so A10 stays clear of auto-precharge
                            cmd_r <= write_r ? CMD_WR : CMD_RD; // RULE9
                            addr_o_r <= {1'b0, sp_col[10], 1'b0, sp_col[9:0]};
                            bank_o_r <= sp_bank;
                            mask_r <= lane_n; // RULE10
                            if (write_r) begin
                                dq_oe_r <= 1'b1;
                                dq_out_r <= wr_word;
                                if (need_second) begin
                                    part_r <= 1'b1;
                                end else begin
                                    part_r <= 1'b0;
                                    ack_r <= 1'b1;
                                    state_r <= ST_IDLE;
                                end
                            end else begin
                                rd_cnt_r <= 5'({3'h0, cas_eff} * MEM_DIV) + RD_EXTRA; // RULE7
                                state_r <= ST_RDWAIT;
                            end
                        end
                        ST_LMR: begin
                            cmd_r <= CMD_LMR;
                            addr_o_r <= {6'h00, 1'b0, cas_eff, 4'h0}; // RULE5
                            bank_o_r <= 2'h0;
                            lmr_need_r <= 1'b0;
                            cas_prog_r <= cas_eff;
                            wait_r <= TMRD_TK;
                            state_r <= ST_IDLE;
                        end
                        ST_REF: begin
                            cmd_r <= CMD_REF;
                            wait_r <= TRFC_TK;
                            state_r <= ST_IDLE;
                        end
                        ST_LOWP: begin
                            cke_r <= 1'b0;
                            asleep_r <= 1'b1;
                            case (sleep_mode_r)
                                MODE_SELF_REF: cmd_r <= CMD_REF;
                                MODE_DEEP_PD: cmd_r <= CMD_DPD;
                                default: cmd_r <= CMD_NOP;
                            endcase
                            state_r <= ST_SLEEP; // RULE8
                        end
                        ST_SLEEP: begin
                            // Power-down holds no refresh of its own, so wake to refresh
                            if (I_MODE != sleep_mode_r ||
                                (sleep_mode_r == MODE_PWR_DOWN && ref_pend_r)) begin
                                cke_r <= 1'b1;
                                asleep_r <= 1'b0;
                                wait_r <= TXSR_TK;
                                if (sleep_mode_r == MODE_DEEP_PD) begin
                                    lmr_need_r <= 1'b1;
                                end
                                state_r <= ST_IDLE;
                            end
                        end
                        default: state_r <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    assign O_BUSY = busy_r;
    assign O_ACK = ack_r;
    assign O_RDATA = rdata_r;
    assign O_ASLEEP = asleep_r;
    assign O_MEM_CLK_OUT = mem_clk_r;
    assign O_MEM_CLK_EN = cke_r;
    assign O_MEM_CHIP_SEL_N = cmd_r[3];
    assign O_ROW_STROBE_N = cmd_r[2];
    assign O_COL_STROBE_N = cmd_r[1];
    assign O_MEM_WRITE_STROBE_N = cmd_r[0];
    assign O_BANK_FIELD = bank_o_r;
    assign O_MEM_ADDR_OUT = addr_o_r;
    assign O_BYTE_LANE_MASK_N = mask_r;
    assign O_DQ_OUT = dq_out_r;
    assign O_DQ_OE = dq_oe_r;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    AST_BUS16_UPPER: assert property ( // RULE1
        (cmd_r == CMD_WR && I_BUS16) |-> mask_r[3:2] == 2'h3)
        else $error("Upper lanes enabled on narrow bus");
    AST_WORD_LANES: assert property ( // RULE4
        (cmd_r == CMD_WR && !I_BUS16 && size_r == SZ_WORD) |-> mask_r == 4'h0)
        else $error("Word write does not enable all lanes");
    AST_LMR_BURST: assert property ( // RULE5
        cmd_r == CMD_LMR |-> addr_o_r[2:0] == 3'h0 && addr_o_r[6:4] == {1'b0, cas_eff})
        else $error("Mode load with wrong burst or latency");
    AST_OPEN_ROW: assert property ( // RULE6
        (cmd_r == CMD_RD || cmd_r == CMD_WR) |->
            open_v_r[bank_o_r] && open_row_r[bank_o_r] == sp_row)
        else $error("Access issued to a row that is not open");
    AST_CAS_MATCH: assert property ( // RULE7
        cmd_r == CMD_RD |-> cas_prog_r == cas_eff && addr_o_r[AP_BIT] == 1'b0 &&
            addr_o_r[9:0] == sp_col[9:0])
        else $error("Read issued with stale latency or wrong column");
    AST_SLEEP_EXIT: assert property ( // RULE8
        (state_r == ST_SLEEP && I_MODE == MODE_RUN) |-> !cke_r ##[1:3] cke_r)
        else $error("Clock enable not restored on wake");
    AST_CKE_ACCESS: assert property ( // RULE9
        (cmd_r == CMD_RD || cmd_r == CMD_WR || cmd_r == CMD_ACT) |-> cke_r && !cmd_r[3])
        else $error("Access with clock enable low");
    AST_ACT_ROW: assert property ( // RULE11
        cmd_r == CMD_ACT |-> addr_o_r == sp_row && bank_o_r == sp_bank)
        else $error("Activate row or bank mismatch");
    AST_REFRESH_DUE: assert property ( // RULE15
        ($rose(ref_pend_r) && I_MODE == MODE_RUN && state_r != ST_SLEEP) |->
            ##[1:60] cmd_r == CMD_REF)
        else $error("Refresh not issued in time");

    COV_READ: cover property (cmd_r == CMD_RD ##[1:20] ack_r);
    COV_WRITE: cover property (cmd_r == CMD_WR && ack_r);
    COV_REFRESH: cover property (cmd_r == CMD_REF && cke_r);
    COV_SLEEP: cover property (state_r == ST_SLEEP ##[1:200] state_r == ST_IDLE);
endmodule

/* File: dv/sdram_chip_model.sv */
// Behavioural SDRAM chip facing the controller's memory pins
`timescale 1ns/1ns
module sdram_chip_model
    import sdram_ctrl_pkg::*;
(
    // Command pins
    input wire logic i_mem_clk,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [1:0] i_bank,
    input wire logic [12:0] i_addr,
    input wire logic [3:0] i_mask_n,
    input wire logic [31:0] i_dq,
    // Data back and observed fields
    output logic [31:0] o_dq,
    output int o_acts,
    output int o_refs,
    output logic [12:0] o_row,
    output logic [10:0] o_col,
    output logic [1:0] o_bank,
    output logic [3:0] o_mask_n
);
    logic [31:0] mem [logic [25:0]];
    logic [12:0] open_row [4];
    logic [2:0] cas = 3'h1;
    logic [3:0] pipe = 4'h0;
    logic [31:0] rd_q;
    logic [25:0] key;
    cmd_t cmd;
    assign cmd = cmd_t'({i_cs_n, i_ras_n, i_cas_n, i_we_n});
    assign key = {i_bank, open_row[i_bank], i_addr[11], i_addr[9:0]};
    initial begin
        o_dq = 32'h0;
        o_acts = 0;
        o_refs = 0;
    end
    always @(posedge i_mem_clk) begin
        // Released bus toggles so a late capture never reads stale data
        o_dq <= (pipe == 4'h1) ? rd_q : ~o_dq;
        if (pipe != 4'h0) pipe <= pipe - 4'h1;
        if (i_cke) begin
            case (cmd)
                CMD_LMR: cas <= i_addr[6:4];
                CMD_REF: o_refs <= o_refs + 1;
                CMD_ACT: begin
                    open_row[i_bank] <= i_addr;
                    o_acts <= o_acts + 1;
                end
                CMD_WR: begin
                    if (!mem.exists(key)) mem[key] = 32'h0;
                    for (int b = 0; b < 4; b++)
                        if (!i_mask_n[b]) mem[key][8*b +: 8] = i_dq[8*b +: 8];
                end
                CMD_RD: begin
                    rd_q <= mem.exists(key) ? mem[key] : 32'h0;
                    // Data must stand at the rising edge that lies latency clocks on
                    if (cas == 3'h1) o_dq <= mem.exists(key) ? mem[key] : 32'h0;
                    pipe <= {1'b0, cas} - 4'h1;
                end
                default: ;
            endcase
            if (cmd == CMD_WR || cmd == CMD_RD) begin
                o_row <= open_row[i_bank];
                o_col <= {i_addr[11], i_addr[9:0]};
                o_bank <= i_bank;
                o_mask_n <= i_mask_n;
            end
        end
    end
endmodule

/* File: dv/sdram_ctrl_tb.sv */
// Self-checking bench for the SDRAM controller front end
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module sdram_ctrl_tb;
    import sdram_ctrl_pkg::*;
    logic clk = 0, rst = 1, req = 0, wr = 0, bus16 = 0;
    logic [27:0] addr = 0;
    logic [1:0] size = 0, col_sel = 0, row_sel = 0, cas = 1, mode = 0, bank, m_bank;
    logic [31:0] wdata = 0, rd, rdv, dq_out, dq_mod, dq;
    logic busy, ack, asleep, mclk, cke, cs_n, ras_n, cas_n, we_n, oe;
    logic [12:0] maddr, m_row;
    logic [10:0] m_col;
    logic [3:0] mask_n, m_mask;
    int num_errors = 0, n_compared = 0, acts, refs, a0, cw, rw;
    always #5 clk = ~clk;
    assign dq = oe ? dq_out : dq_mod;
    sdram_ctrl sdram_ctrl_i (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_WRITE(wr),
        .I_ADDR(addr), .I_SIZE(size), .I_WDATA(wdata), .O_BUSY(busy), .O_ACK(ack),
        .O_RDATA(rd), .I_BUS16(bus16), .I_COL_SEL(col_sel), .I_ROW_SEL(row_sel),
        .I_CAS_LAT(cas), .I_MODE(mode), .O_ASLEEP(asleep), .O_MEM_CLK_OUT(mclk),
        .O_MEM_CLK_EN(cke), .O_MEM_CHIP_SEL_N(cs_n), .O_ROW_STROBE_N(ras_n),
        .O_COL_STROBE_N(cas_n), .O_MEM_WRITE_STROBE_N(we_n), .O_BANK_FIELD(bank),
        .O_MEM_ADDR_OUT(maddr), .O_BYTE_LANE_MASK_N(mask_n), .O_DQ_OUT(dq_out),
        .O_DQ_OE(oe), .I_DQ_IN(dq));
    sdram_chip_model sdram_chip_model_i (.i_mem_clk(mclk), .i_cke(cke), .i_cs_n(cs_n),
        .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank(bank), .i_addr(maddr),
        .i_mask_n(mask_n), .i_dq(dq), .o_dq(dq_mod), .o_acts(acts), .o_refs(refs),
        .o_row(m_row), .o_col(m_col), .o_bank(m_bank), .o_mask_n(m_mask));
    task automatic complete_run();
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic restart(input logic b16, input logic [1:0] cs, input logic [1:0] rs);
        @(negedge clk);
        rst = 1;
        bus16 = b16;
        col_sel = cs;
        row_sel = rs;
        repeat (5) @(negedge clk);
        `CHK({cs_n, ras_n, cas_n, we_n, cke}, 5'h0f);
        rst = 0;
    endtask
    // Request is held until the controller shows it was taken
    task automatic acc(input logic w, input logic [27:0] a, input logic [1:0] sz,
                       input logic [31:0] d);
        int k;
        @(negedge clk);
        req = 1;
        wr = w;
        addr = a;
        size = sz;
        wdata = d;
        for (k = 0; k < 300 && busy !== 1'b1 && ack !== 1'b1; k++) @(negedge clk);
        req = 0;
        // A request that is never taken counts as a hang as well
        for (k = (k >= 300) ? 600 : k; k < 600 && ack !== 1'b1; k++) @(negedge clk);
        if (k >= 600) begin
            num_errors++;
            complete_run();
        end
        rdv = rd;
        @(negedge clk);
    endtask
    task automatic wait_asleep(input logic v);
        int k;
        for (k = 0; k < 400 && asleep !== v; k++) @(negedge clk);
        if (k == 400) begin
            num_errors++;
            complete_run();
        end
    endtask
    initial begin
        for (int rs = 0; rs < 3; rs++) for (int cs = 0; cs < 4; cs++) begin
            restart(0, cs[1:0], rs[1:0]);
            cw = 8 + cs;
            rw = 11 + rs;
            a0 = 28'h9e3779c & ((1 << (4 + cw + rw)) - 1);
            acc(1, a0[27:0], SZ_WORD, {16'hc0de, a0[15:0]});
            `CHK(m_col, 11'((a0 >> 2) & ((1 << cw) - 1)));
            `CHK(m_row, 13'((a0 >> (2 + cw)) & ((1 << rw) - 1)));
            `CHK(m_bank, 2'(a0 >> (2 + cw + rw)));
            acc(0, a0[27:0], SZ_WORD, 32'h0);
            `CHK(rdv, {16'hc0de, a0[15:0]});
        end
        for (int c = 1; c < 4; c++) begin
            cas = c[1:0];
            acc(1, 28'h40 * c, SZ_WORD, 32'h11111111 * c);
            acc(0, 28'h40 * c, SZ_WORD, 32'h0);
            `CHK(rdv, 32'h11111111 * c);
        end
        acc(1, 28'h100, SZ_WORD, 32'h44332211);
        acc(1, 28'h101, SZ_BYTE, 32'h0000aa00);
        `CHK(m_mask, 4'hd);
        acc(1, 28'h102, SZ_HALF, 32'hbbcc0000);
        `CHK(m_mask, 4'h3);
        acc(0, 28'h100, SZ_WORD, 32'h0);
        `CHK(rdv, 32'hbbccaa11);
        a0 = acts;
        cw = refs;
        // A refresh in between closes all rows, so one reopen is then due
        acc(0, 28'h104, SZ_WORD, 32'h0);
        `CHK(acts - a0, (refs != cw) ? 1 : 0);
        cw = refs;
        repeat (1600) @(negedge clk);
        `CHK(refs - cw >= 2 && refs - cw <= 3, 1'b1);
        for (int m = 1; m < 4; m++) begin
            mode = m[1:0];
            wait_asleep(1'b1);
            `CHK(cke, 1'b0);
            mode = 2'h0;
            wait_asleep(1'b0);
            `CHK(cke, 1'b1);
            acc(1, 28'h200, SZ_WORD, 32'h600d0000 | m);
            acc(0, 28'h200, SZ_WORD, 32'h0);
            `CHK(rdv, 32'h600d0000 | m);
        end
        restart(1, 2'h0, 2'h0);
        acc(1, 28'h310, SZ_WORD, 32'hfeedbeef);
        acc(0, 28'h310, SZ_WORD, 32'h0);
        `CHK(rdv, 32'hfeedbeef);
        complete_run();
    end
endmodule
